// *** desc_queue_manager.sv ***
/*
  Descriptor queue manager: per-queue push/pop word, push control word,
  side-effect-free peek window with threshold configuration, a push port
  for the packet DMA engine and a prefetch request toward it.
  Assumes a single-cycle register master on clk_i and a DMA engine that
  only pushes while no register strobe is present.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module desc_queue_manager #(
  parameter int NUM_QUEUES  = qm_pkg::QUEUE_COUNT,
  parameter int QUEUE_DEPTH = qm_pkg::DEFAULT_DEPTH
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_b_i,
  input  wire logic [$clog2(NUM_QUEUES)+4:0]         addr_i,
  input  wire logic [31:0]                           wdata_i,
  input  wire logic                                  wr_i,
  input  wire logic                                  rd_i,
  output logic      [31:0]                           rdata_o,
  input  wire logic                                  dma_push_i,
  input  wire logic [$clog2(NUM_QUEUES)-1:0]         dma_queue_i,
  input  wire logic [qm_pkg::DESC_ADDR_W-1:0]        dma_addr_i,
  input  wire logic [qm_pkg::HINT_W-1:0]             dma_hint_i,
  input  wire logic                                  dma_tx_return_i,
  output logic                                       fetch_valid_o,
  output logic      [31:0]                           fetch_addr_o,
  output logic      [qm_pkg::FETCH_W-1:0]            fetch_bytes_o,
  output logic      [NUM_QUEUES-1:0]                 thr_status_o
);

  localparam int QW     = $clog2(NUM_QUEUES);
  localparam int PW     = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
  localparam int CW     = PW + 1;
  localparam int REGION = QW + qm_pkg::STRIDE_LSB;
  localparam logic [CW-1:0] DEPTH_C = CW'(QUEUE_DEPTH);

  typedef struct packed {
    logic [31:0]                   rdata;
    logic                          fetch_valid;
    logic [31:0]                   fetch_addr;
    logic [qm_pkg::FETCH_W-1:0]    fetch_bytes;
    logic                          cap_head;
    logic [qm_pkg::PKT_SIZE_W-1:0] cap_size;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // storage: one ring of QUEUE_DEPTH slots per queue, head moves both ways
  logic [31:0]                   desc_mem [NUM_QUEUES*QUEUE_DEPTH];
  logic [qm_pkg::PKT_SIZE_W-1:0] size_mem [NUM_QUEUES*QUEUE_DEPTH];
  logic [PW-1:0]                 head_mem [NUM_QUEUES];
  logic [CW-1:0]                 cnt_mem  [NUM_QUEUES];
  logic [31:0]                   byte_mem [NUM_QUEUES];
  logic [7:0]                    cfg_mem  [NUM_QUEUES];
  logic [NUM_QUEUES-1:0]         thr_reg;

  thr_if th ();

  thr_eval u_thr_eval (
    .th (th.eval)
  );

  logic [QW-1:0]                 bus_q;
  logic [3:0]                    word;
  logic                          peek;
  logic                          bus_push;
  logic                          bus_pop;
  logic                          dma_take;
  logic                          push;
  logic [QW-1:0]                 op_q;
  logic [31:0]                   push_word;
  logic                          flush;
  logic                          full;
  logic [CW-1:0]                 cur_cnt;
  logic [PW-1:0]                 cur_head;
  logic [31:0]                   cur_bytes;
  logic [QW+PW-1:0]              head_idx;
  logic [31:0]                   head_desc;
  logic [qm_pkg::PKT_SIZE_W-1:0] head_size;
  logic                          q_we;
  logic [CW-1:0]                 cnt_n;
  logic [PW-1:0]                 head_n;
  logic [31:0]                   bytes_n;
  logic                          mem_we;
  logic [QW+PW-1:0]              mem_idx;
  logic                          cfg_we;
  logic [7:0]                    cfg_n;
  logic [32:0]                   byte_sum;
  logic [qm_pkg::PKT_SIZE_W-1:0] push_size;

  always_comb begin
    bus_q     = addr_i[REGION-1:qm_pkg::STRIDE_LSB];
    word      = {addr_i[3:2], 2'b00};
    peek      = addr_i[REGION];
    bus_push  = wr_i && !peek && (word == qm_pkg::OFF_PUSH_POP);
    bus_pop   = rd_i && !peek && (word == qm_pkg::OFF_PUSH_POP);
    dma_take  = dma_push_i && !wr_i && !rd_i;
    push      = bus_push || dma_take;
    op_q      = dma_take ? dma_queue_i : bus_q;
    if (dma_take) begin
      // returned transmit descriptors carry no prefetch hint
      push_word = {dma_addr_i, dma_tx_return_i ? 4'h0 : dma_hint_i};
    end else begin
      push_word = wdata_i;
    end
    push_size = dma_take ? '0 : state_reg.cap_size;
    flush     = push && (push_word[31:qm_pkg::DESC_ADDR_LSB] == '0);
    cur_cnt   = cnt_mem[op_q];
    cur_head  = head_mem[op_q];
    cur_bytes = byte_mem[op_q];
    full      = (cur_cnt == DEPTH_C);
    head_idx  = {op_q, cur_head};
    head_desc = desc_mem[head_idx];
    head_size = size_mem[head_idx];

    state_next             = state_reg;
    state_next.rdata       = '0;
    state_next.fetch_valid = 1'b0;
    q_we     = 1'b0;
    cnt_n    = cur_cnt;
    head_n   = cur_head;
    bytes_n  = cur_bytes;
    mem_we   = 1'b0;
    mem_idx  = head_idx;
    cfg_we   = 1'b0;
    cfg_n    = cfg_mem[op_q];
    byte_sum = {1'b0, cur_bytes} + 33'(push_size);

    if (flush) begin
      q_we    = 1'b1;
      cnt_n   = '0;
      head_n  = '0;
      bytes_n = '0;
    end else if (push && !full) begin
      q_we   = 1'b1;
      mem_we = 1'b1;
      cnt_n  = cur_cnt + 1'b1;
      if (state_reg.cap_head && !dma_take) begin
        head_n  = cur_head - 1'b1;
        mem_idx = {op_q, head_n};
      end else begin
        mem_idx = {op_q, PW'(cur_head + cur_cnt[PW-1:0])};
      end
      bytes_n = byte_sum[32] ? qm_pkg::BYTE_COUNT_MAX : byte_sum[31:0];
    end else if (bus_pop && (cur_cnt != '0)) begin
      q_we    = 1'b1;
      cnt_n   = cur_cnt - 1'b1;
      head_n  = cur_head + 1'b1;
      bytes_n = (cur_bytes > 32'(head_size)) ? cur_bytes - 32'(head_size) : '0;
    end
    // an empty pop falls through with every queue array untouched

    if (bus_push) begin
      // control word is single use: the next push goes back to tail, size 0
      state_next.cap_head = 1'b0;
      state_next.cap_size = '0;
    end
    if (wr_i && !peek && (word == qm_pkg::OFF_PUSH_CTRL)) begin
      state_next.cap_head = wdata_i[qm_pkg::HEAD_TAIL_BIT];
      state_next.cap_size = wdata_i[qm_pkg::PKT_SIZE_W-1:0];
    end
    if (wr_i && peek && (word == qm_pkg::OFF_THRESHOLD)) begin
      cfg_we = 1'b1;
      cfg_n  = wdata_i[7:0] & qm_pkg::THR_CFG_MASK;
    end

    if (bus_pop) begin
      if (cur_cnt != '0) begin
        state_next.rdata       = head_desc;
        state_next.fetch_valid = 1'b1;
        state_next.fetch_addr  = {head_desc[31:qm_pkg::DESC_ADDR_LSB], 4'h0};
        // fetch exactly the hinted length; a short hint is the pusher's fault
        state_next.fetch_bytes = qm_pkg::FETCH_W'(
          {5'h00, head_desc[qm_pkg::HINT_W-1:0]} + 9'h001) << qm_pkg::HINT_UNIT_LSB;
      end else begin
        state_next.rdata = '0;
      end
    end else if (rd_i && peek) begin
      unique case (word)
        qm_pkg::OFF_ENTRY_COUNT: state_next.rdata = 32'(cur_cnt);
        qm_pkg::OFF_BYTE_COUNT:  state_next.rdata = cur_bytes;
        qm_pkg::OFF_HEAD_SIZE:   state_next.rdata = (cur_cnt != '0) ? 32'(head_size) : '0;
        qm_pkg::OFF_THRESHOLD:   state_next.rdata = 32'(cfg_mem[op_q]);
        default:                 state_next.rdata = '0;
      endcase
    end

    th.count       = qm_pkg::ENTRY_W'(cnt_n);
    th.config_word = cfg_n;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      thr_reg <= '0;
      for (int i = 0; i < NUM_QUEUES; i++) begin
        head_mem[i] <= '0;
        cnt_mem[i]  <= '0;
        byte_mem[i] <= '0;
        cfg_mem[i]  <= qm_pkg::THR_CFG_RESET;
      end
    end else begin
      if (q_we) begin
        head_mem[op_q] <= head_n;
        cnt_mem[op_q]  <= cnt_n;
        byte_mem[op_q] <= bytes_n;
      end
      if (cfg_we) begin
        cfg_mem[op_q] <= cfg_n;
      end
      if (q_we || cfg_we) begin
        thr_reg[op_q] <= th.status;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      desc_mem[mem_idx] <= push_word;
      size_mem[mem_idx] <= push_size;
    end
  end

  assign rdata_o       = state_reg.rdata;
  assign fetch_valid_o = state_reg.fetch_valid;
  assign fetch_addr_o  = state_reg.fetch_addr;
  assign fetch_bytes_o = state_reg.fetch_bytes;
  assign thr_status_o  = thr_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_POP_HEAD: assert property (bus_pop && cur_cnt != '0 |=> rdata_o == $past(head_desc))
    else $error("pop did not return head descriptor");
  AST_POP_EMPTY_ADDR: assert property (bus_pop && cur_cnt == '0 |=> rdata_o[31:4] == '0)
    else $error("empty pop returned nonzero address");
  AST_POP_EMPTY_HINT: assert property (bus_pop && cur_cnt == '0 |=> rdata_o[3:0] == 4'h0)
    else $error("empty pop returned nonzero hint");
  AST_FLUSH: assert property (bus_push && flush |=> cnt_mem[$past(op_q)] == '0)
    else $error("zero address write did not empty queue");
  AST_FETCH_LEN: assert property (bus_pop && cur_cnt != '0 |=> fetch_valid_o &&
      fetch_bytes_o == 9'(({5'h00, $past(head_desc[3:0])} + 9'h001) * 9'h010))
    else $error("fetch length differs from hint");
  AST_CNT_INC: assert property (push && !flush && !full |=>
      cnt_mem[$past(op_q)] == $past(cur_cnt) + 1'b1)
    else $error("push did not raise entry count by one");
  AST_CNT_DEC: assert property (bus_pop && cur_cnt != '0 ##1 rd_i && peek &&
      word == qm_pkg::OFF_ENTRY_COUNT && bus_q == $past(op_q) |=>
      rdata_o == 32'($past(cur_cnt, 2)) - 32'h1)
    else $error("pop did not lower entry count by one");
  AST_EMPTY_HOLD: assert property (bus_pop && cur_cnt == '0 |=>
      cnt_mem[$past(op_q)] == '0 && byte_mem[$past(op_q)] == $past(cur_bytes))
    else $error("empty pop changed queue state");
  AST_TXRET_HINT: assert property (dma_take && dma_tx_return_i && !flush && !full |=>
      desc_mem[$past(mem_idx)][3:0] == 4'h0)
    else $error("transmit return push kept a hint");
  AST_PEEK_NOSIDE: assert property (rd_i && peek |=> cnt_mem[$past(op_q)] == $past(cur_cnt))
    else $error("peek read changed entry count");
  AST_THR_ZERO: assert property (wr_i && peek && word == qm_pkg::OFF_THRESHOLD &&
      wdata_i[7] && wdata_i[3:0] == 4'h0 |=> thr_status_o[$past(bus_q)])
    else $error("zero threshold at-least status not set");
  AST_PEEK_HEAD_EMPTY: assert property (rd_i && peek && word == qm_pkg::OFF_HEAD_SIZE &&
      cur_cnt == '0 |=> rdata_o == '0)
    else $error("head size peek of empty queue not zero");
  AST_FULL_KEEP: assert property (push && full && !flush |=>
      cnt_mem[$past(op_q)] == $past(cur_cnt))
    else $error("push into full queue changed entry count");

  COV_POP_DATA: cover property (bus_pop && cur_cnt != '0 ##1 fetch_valid_o);
  COV_HEAD_PUSH: cover property (push && state_reg.cap_head && !full);
  COV_FULL_DROP: cover property (push && full && !flush);
  COV_FLUSH: cover property (bus_push && flush && cur_cnt != '0);
  COV_TX_RETURN: cover property (dma_take && dma_tx_return_i && !full);

endmodule : desc_queue_manager

// *** desc_queue_manager_tb.sv ***
/*
  Self-checking bench for the descriptor queue manager with a queue-based
  reference model. Assumes a small instance of sixteen queues, depth four.
*/
`timescale 1ns/10ps
module desc_queue_manager_tb;
  localparam int NQ = 16;
  localparam int QW = 4;
  localparam int AW = QW + 5;
  typedef struct packed {logic [31:0] data; logic is_pop;} exp_type;
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o, fetch_addr_o;
  logic fetch_valid_o, dma_push, dma_tx, dma_req = 1'b0, req_tx = 1'b0, req_ant = 1'b0;
  logic [8:0] fetch_bytes_o;
  logic [NQ-1:0] thr_status_o;
  logic [QW-1:0] dma_q, req_q = '0;
  logic [27:0] dma_a, req_a = '0;
  logic [3:0] dma_h, req_h = '0;
  logic [31:0] mq [NQ][$];
  logic [16:0] ms [NQ][$];
  logic [7:0] cfg [NQ];
  exp_type exp_q [$];
  exp_type cur;
  logic [31:0] w;
  int n_fail = 0, total_checks = 0;

  always #20 clk_i = ~clk_i;

  desc_queue_manager #(.NUM_QUEUES(NQ), .QUEUE_DEPTH(4)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .dma_push_i(dma_push), .dma_queue_i(dma_q),
    .dma_addr_i(dma_a), .dma_hint_i(dma_h), .dma_tx_return_i(dma_tx),
    .fetch_valid_o(fetch_valid_o), .fetch_addr_o(fetch_addr_o),
    .fetch_bytes_o(fetch_bytes_o), .thr_status_o(thr_status_o));

  dma_model #(.QW(QW)) far_end (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(dma_req), .queue_req_i(req_q),
    .addr_req_i(req_a), .hint_req_i(req_h), .tx_return_req_i(req_tx),
    .antenna_req_i(req_ant), .dma_push_o(dma_push), .dma_queue_o(dma_q),
    .dma_addr_o(dma_a), .dma_hint_o(dma_h), .dma_tx_return_o(dma_tx));

  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [AW-1:0] adr(int pk, int q, int off);
    return AW'(pk * 256 + q * 16 + off);
  endfunction : adr

  function automatic logic [31:0] bytes_of(int q);
    logic [31:0] s;
    s = '0;
    foreach (ms[q][i]) s += 32'(ms[q][i]);
    return s;
  endfunction : bytes_of

  function automatic logic thr_exp(int cnt, logic [7:0] c);
    int t;
    t = (c[3:0] == 4'h0) ? 0 : (c[3:0] >= 4'ha) ? 1023 : (1 << c[3:0]) - 1;
    return c[7] ? (cnt >= t) : (cnt < t);
  endfunction : thr_exp

  task automatic bus(logic wr, logic [AW-1:0] a, logic [31:0] d);
    @(posedge clk_i);
    wr_i <= wr;
    rd_i <= !wr;
    addr_i <= a;
    wdata_i <= d;
  endtask : bus

  task automatic idle();
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    dma_req <= 1'b0;
  endtask : idle

  task automatic rd(logic [AW-1:0] a, logic [31:0] e, logic p);
    exp_q.push_back('{e, p});
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic push(int q, logic ht, logic [16:0] sz, logic [27:0] da, logic [3:0] h);
    bus(1'b1, adr(0, q, 8), {ht, 14'h0, sz});
    // one in-order master: every earlier write has landed before this push
    bus(1'b1, adr(0, q, 12), {da, h});
    if (mq[q].size() < 4 && ht) begin
      mq[q].push_front({da, h});
      ms[q].push_front(sz);
    end else if (mq[q].size() < 4) begin
      mq[q].push_back({da, h});
      ms[q].push_back(sz);
    end
  endtask : push

  task automatic pop(int q);
    logic [31:0] e;
    e = '0;
    if (mq[q].size() > 0) begin
      e = mq[q].pop_front();
      void'(ms[q].pop_front());
    end
    rd(adr(0, q, 12), e, 1'b1);
  endtask : pop

  task automatic peek(int q);
    rd(adr(1, q, 0), 32'(mq[q].size()), 1'b0);
    rd(adr(1, q, 4), bytes_of(q), 1'b0);
    rd(adr(1, q, 8), (mq[q].size() > 0) ? 32'(ms[q][0]) : 32'h0, 1'b0);
    rd(adr(1, q, 12), 32'(cfg[q]), 1'b0);
  endtask : peek

  task automatic dma(int q, logic [3:0] h, logic tx, logic ant);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    dma_req <= 1'b1;
    req_q <= QW'(q);
    req_a <= 28'($urandom) | 28'h1;
    req_h <= h;
    req_tx <= tx;
    req_ant <= ant;
    @(posedge clk_i);
    dma_req <= 1'b0;
    mq[q].push_back({req_a, tx ? 4'h0 : ant ? 4'h3 : h});
    ms[q].push_back(17'h0);
  endtask : dma

  // results appear one cycle after the read strobe
  always @(posedge clk_i) begin
    if (rd_seen) begin
      cur = exp_q.pop_front();
      chk("read data", cur.data, rdata_o);
      if (cur.is_pop) begin
        chk("fetch valid", 32'(cur.data != 0), 32'(fetch_valid_o));
        if (cur.data != 0) begin
          chk("fetch addr", {cur.data[31:4], 4'h0}, fetch_addr_o);
          chk("fetch bytes", (32'(cur.data[3:0]) + 1) * 16, 32'(fetch_bytes_o));
        end
      end
    end
    rd_seen <= rd_i;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hf7d11228));
    for (int q = 0; q < NQ; q++) cfg[q] = 8'h81;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    peek(3);
    pop(3);
    peek(3);
    for (int i = 0; i < 16; i++) begin
      push(1, i % 3 == 1, 17'($urandom), 28'($urandom) | 28'h1, 4'(i));
      peek(1);
      if (i % 3 == 2) begin
        pop(1);
        peek(1);
      end
    end
    for (int off = 0; off < 12; off += 4) rd(adr(0, 1, off), 32'h0, 1'b0);
    for (int off = 0; off < 12; off += 4) bus(1'b1, adr(1, 1, off), $urandom);
    peek(1);
    bus(1'b1, adr(0, 1, 12), 32'h0);
    mq[1].delete();
    ms[1].delete();
    peek(1);
    pop(1);
    for (int i = 0; i < 3; i++) push(2, 1'b0, 17'h10, 28'($urandom) | 28'h1, 4'h1);
    for (int f = 0; f < 32; f++) begin
      w = $urandom;
      w[3:0] = 4'(f);
      w[7] = f[4];
      bus(1'b1, adr(1, 2, 12), w);
      cfg[2] = w[7:0] & 8'h8f;
      idle();
      @(negedge clk_i);
      chk("threshold status", 32'(thr_exp(3, cfg[2])), 32'(thr_status_o[2]));
      rd(adr(1, 2, 12), 32'(cfg[2]), 1'b0);
    end
    dma(5, 4'($urandom), 1'b1, 1'b0);
    dma(5, 4'($urandom), 1'b0, 1'b1);
    dma(5, 4'($urandom), 1'b0, 1'b0);
    peek(5);
    for (int i = 0; i < 4; i++) pop(5);
    idle();
    idle();
    idle();
    wrap_up();
  end
endmodule : desc_queue_manager_tb

// *** dma_model.sv ***
/*
  Behavioural packet DMA engine standing at the queue manager's push port.
  Assumes the bench raises req_i only while no register strobe is present.
*/
`timescale 1ns/10ps
module dma_model #(
  parameter int QW = 4
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          req_i,
  input  wire logic [QW-1:0] queue_req_i,
  input  wire logic [27:0]   addr_req_i,
  input  wire logic [3:0]    hint_req_i,
  input  wire logic          tx_return_req_i,
  input  wire logic          antenna_req_i,
  output logic               dma_push_o,
  output logic [QW-1:0]      dma_queue_o,
  output logic [27:0]        dma_addr_o,
  output logic [3:0]         dma_hint_o,
  output logic               dma_tx_return_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_push_o      <= 1'b0;
      dma_queue_o     <= '0;
      dma_addr_o      <= '0;
      dma_hint_o      <= '0;
      dma_tx_return_o <= 1'b0;
    end else if (req_i) begin
      dma_push_o      <= 1'b1;
      dma_queue_o     <= queue_req_i;
      dma_addr_o      <= addr_req_i;
      // monolithic antenna descriptors always carry hint three
      dma_hint_o      <= antenna_req_i ? 4'h3 : hint_req_i;
      dma_tx_return_o <= tx_return_req_i;
    end else begin
      // released fields toggle so a stale value can never pass for a push
      dma_push_o      <= 1'b0;
      dma_queue_o     <= ~dma_queue_o;
      dma_addr_o      <= ~dma_addr_o;
      dma_hint_o      <= ~dma_hint_o;
      dma_tx_return_o <= ~dma_tx_return_o;
    end
  end
endmodule : dma_model

// *** qm_pkg.sv ***
/*
  Shared constants for the descriptor queue manager: word offsets inside a
  queue's sixteen-byte stride, field positions, reset values and the
  threshold encoding. Assumes nothing of its surroundings.
*/
package qm_pkg;

  localparam int QUEUE_COUNT   = 8192;
  localparam int DEFAULT_DEPTH = 4;

  // word offsets inside one queue's stride, both regions
  localparam logic [3:0] OFF_ENTRY_COUNT = 4'h0;
  localparam logic [3:0] OFF_BYTE_COUNT  = 4'h4;
  localparam logic [3:0] OFF_HEAD_SIZE   = 4'h8;
  localparam logic [3:0] OFF_THRESHOLD   = 4'hc;
  localparam logic [3:0] OFF_PUSH_CTRL   = 4'h8;
  localparam logic [3:0] OFF_PUSH_POP    = 4'hc;
  localparam int         STRIDE_LSB      = 4;

  // push/pop word layout
  localparam int DESC_ADDR_LSB = 4;
  localparam int DESC_ADDR_W   = 28;
  localparam int HINT_W        = 4;
  localparam int HINT_UNIT_LSB = 4;
  localparam int FETCH_W       = 9;

  // push control word layout
  localparam int HEAD_TAIL_BIT = 31;
  localparam int PKT_SIZE_W    = 17;

  // entry count and threshold layout
  localparam int         ENTRY_W         = 19;
  localparam int         THR_HILO_BIT    = 7;
  localparam int         THR_FIELD_W     = 4;
  localparam int         THR_INT_W       = 10;
  localparam logic [7:0] THR_CFG_MASK    = 8'h8f;
  localparam logic [7:0] THR_CFG_RESET   = 8'h81;
  localparam logic [3:0] THR_SAT_FROM    = 4'ha;
  localparam logic [9:0] THR_SAT_VALUE   = 10'h3ff;
  localparam logic [31:0] BYTE_COUNT_MAX = 32'hffffffff;

endpackage : qm_pkg

// *** thr_eval.sv ***
/*
  Threshold evaluator: expands the four-bit threshold field to its ten-bit
  internal value and compares the entry count against it in the direction
  the high/low bit selects. Assumes the caller registers the result.
*/
`timescale 1ns/10ps
module thr_eval (
  thr_if.eval th
);

  function automatic logic [qm_pkg::THR_INT_W-1:0] thr_decode(
    input logic [qm_pkg::THR_FIELD_W-1:0] field
  );
    logic [qm_pkg::THR_INT_W:0] one_hot;
    one_hot = '0;
    if (field == '0) begin
      return '0;
    end else if (field >= qm_pkg::THR_SAT_FROM) begin
      return qm_pkg::THR_SAT_VALUE;
    end else begin
      one_hot = (qm_pkg::THR_INT_W + 1)'(1) << field;
      return qm_pkg::THR_INT_W'(one_hot - 1'b1);
    end
  endfunction : thr_decode

  logic [qm_pkg::ENTRY_W-1:0] limit;

  always_comb begin
    limit = qm_pkg::ENTRY_W'(thr_decode(th.config_word[qm_pkg::THR_FIELD_W-1:0]));
    if (th.config_word[qm_pkg::THR_HILO_BIT]) begin
      th.status = (th.count >= limit);
    end else begin
      th.status = (th.count < limit);
    end
  end

endmodule : thr_eval

// *** thr_if.sv ***
/*
  Carrier between the queue manager and its threshold evaluator: the
  updated entry count, the threshold word and the resulting status bit.
  Assumes both ends sit in the same clock domain; the path is combinational.
*/
`timescale 1ns/10ps
interface thr_if;
  logic [qm_pkg::ENTRY_W-1:0] count;
  logic [7:0]                 config_word;
  logic                       status;

  modport eval (input count, input config_word, output status);
  modport user (output count, output config_word, input status);
endinterface : thr_if
